// ### src/pdm_consts.vh
/*
 * constants for the power-down mode controller: register offsets, field
 * positions, mode codes and timing counts.
 * assumes inclusion by bare name from the design and verification files.
 */
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// ----------------------------------------------------------------------------
// register map (word offsets on the plain register port)
// ----------------------------------------------------------------------------
`define PDM_ADDR_W 4
`define PDM_OFS_CTRL_STATUS 4'h0
`define PDM_OFS_PD_STATUS 4'h1
`define PDM_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// control_status_word fields
// ----------------------------------------------------------------------------
`define PDM_POWER_DOWN_SELECT_HI 15
`define PDM_POWER_DOWN_SELECT_LO 10
`define PDM_GIE_BIT 0
`define PDM_CTRL_WMASK 32'h0000_fc01

// ----------------------------------------------------------------------------
// power_down_select codes
// ----------------------------------------------------------------------------
`define PDM_CODE_NONE 6'h00
`define PDM_CODE_LIGHT_EN 6'h09
`define PDM_CODE_LIGHT_ANY 6'h11
`define PDM_CODE_HALT 6'h1a
`define PDM_CODE_PLL_STOP 6'h1c

// ----------------------------------------------------------------------------
// entry delay after the select write
// ----------------------------------------------------------------------------
`define PDM_ENTRY_CYCLES 4'h9
`define PDM_CNT_W 4

`endif

// ### src/pdm_entry_delay.v
/*
 * entry delay counter: after a load pulse counts a fixed number of cycles
 * and then pulses done once.
 * assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "pdm_consts.vh"

module pdm_entry_delay (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // control
    input wire i_load,
    input wire i_cancel,
    output reg o_done,
    output wire o_busy
);

    reg [`PDM_CNT_W-1:0] cnt_q;

    assign o_busy = (cnt_q != {`PDM_CNT_W{1'b0}});

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= {`PDM_CNT_W{1'b0}};
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_cancel) begin
                cnt_q <= {`PDM_CNT_W{1'b0}};
            end else if (i_load) begin
                cnt_q <= `PDM_ENTRY_CYCLES;
            end else if (o_busy) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule // pdm_entry_delay

// ### src/pdm_power_down.v
/*
 * power-down mode controller: holds the control_status_word, decodes the
 * power_down_select field and drives clock gates, pll enables, output
 * freeze and wake-up control toward the core.
 * assumes the core interrupt logic, pll and emulation logic sit outside;
 * emulator and interrupt inputs arrive from other domains and are synchronised.
 */
// Contract
// - mode and wake method come from select field bits 15 to 10.
// - selected mode takes effect nine cycles after the select write; the code applies it ten cycles after.
// - code 000000 means run; 001001 light sleep woken by enabled interrupt.
// - code 010001 light sleep woken by any interrupt.
// - light sleep gates cpu clocks, interrupt logic keeps running.
// - enhanced transfer engine keeps its clock during light sleep.
// - wake by non-enabled interrupt resumes at sleep point, no service routine.
// - wake by enabled interrupt runs service routine then resumes.
// - service routine only if both interrupt gates set, else just resume.
// - code 011010 halts pll output, state is kept.
// - code 011100 stops pll input, slower wake needing relock.
// - deep modes leave only by device reset, interrupts ignored.
// - deep modes freeze functional outputs at last state.
// - gating acts on reference clock input only; the code also gates the cpu clock, transfer clock and pll output.
// - attached emulator masks power-down until emulator reset or removed.
// - in deep modes emulation commands spin idle, pc writes fail.
`timescale 1ns/1ps
`include "pdm_consts.vh"

module pdm_power_down (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // register port
    input wire [`PDM_ADDR_W-1:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // core side
    input wire i_nmi_gate,
    input wire i_irq_any,
    input wire i_irq_enabled,
    // emulation side
    input wire i_emu_attached,
    input wire i_emu_exec_cmd,
    input wire i_emu_pc_write,
    // clock tree and pll
    output reg o_cpu_clk_en,
    output reg o_xfer_clk_en,
    output reg o_pll_out_en,
    output reg o_refclk_en,
    output reg o_io_freeze,
    // wake and emulation answers
    output reg o_run_isr,
    output reg o_resume,
    output reg o_emu_spin_idle,
    output reg o_emu_pc_write_fail
);

    // ------------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------------
    localparam ST_RUN = 2'b00;
    localparam ST_LIGHT = 2'b01;
    localparam ST_HALT = 2'b10;
    localparam ST_PLL_STOP = 2'b11;

    localparam WAKE_NONE = 2'b00;
    localparam WAKE_EN = 2'b01;
    localparam WAKE_ANY = 2'b10;

    // ------------------------------------------------------------------------
    // decode of the select code
    // ------------------------------------------------------------------------
    function [1:0] code_state;
        input [5:0] code;
        begin
            case (code)
                `PDM_CODE_LIGHT_EN: code_state = ST_LIGHT;
                `PDM_CODE_LIGHT_ANY: code_state = ST_LIGHT;
                `PDM_CODE_HALT: code_state = ST_HALT;
                `PDM_CODE_PLL_STOP: code_state = ST_PLL_STOP;
                default: code_state = ST_RUN;
            endcase
        end
    endfunction

    function [1:0] code_wake;
        input [5:0] code;
        begin
            if (code == `PDM_CODE_LIGHT_EN) begin
                code_wake = WAKE_EN;
            end else if (code == `PDM_CODE_LIGHT_ANY) begin
                code_wake = WAKE_ANY;
            end else begin
                code_wake = WAKE_NONE;
            end
        end
    endfunction

    function is_deep;
        input [1:0] st;
        begin
            is_deep = (st == ST_HALT) || (st == ST_PLL_STOP);
        end
    endfunction

    // ------------------------------------------------------------------------
    // synchronisers for inputs from other domains
    // ------------------------------------------------------------------------
    // the nonmaskable gate comes from core logic on this clock and is read directly
    localparam SYNC_W = 5;

    wire [SYNC_W-1:0] sync_in = {i_emu_pc_write, i_emu_exec_cmd, i_emu_attached, i_irq_enabled, i_irq_any};
    wire [SYNC_W-1:0] sync_out;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            reg stage1_q;
            reg stage2_q;

            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                end else begin
                    stage1_q <= sync_in[gi];
                    stage2_q <= stage1_q;
                end
            end

            assign sync_out[gi] = stage2_q;
        end
    endgenerate

    wire irq_any = sync_out[0];
    wire irq_en = sync_out[1];
    wire emu_att = sync_out[2];
    wire emu_cmd = sync_out[3];
    wire emu_pcw = sync_out[4];

    // ------------------------------------------------------------------------
    // control_status_word and register port
    // ------------------------------------------------------------------------
    reg [31:0] ctrl_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] wake_q;

    wire [5:0] sel = ctrl_q[`PDM_POWER_DOWN_SELECT_HI:`PDM_POWER_DOWN_SELECT_LO];
    wire global_interrupt_gate = ctrl_q[`PDM_GIE_BIT];
    wire sel_wr = i_wr && (i_addr == `PDM_OFS_CTRL_STATUS);
    wire deep = is_deep(state_q);
    wire entry_done;
    wire entry_busy;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= `PDM_CTRL_RESET;
        end else if (state_q == ST_LIGHT && state_d == ST_RUN) begin
            // leaving light sleep returns the field to run
            ctrl_q[`PDM_POWER_DOWN_SELECT_HI:`PDM_POWER_DOWN_SELECT_LO] <= `PDM_CODE_NONE;
        end else if (sel_wr && !deep) begin
            // whole field written at once; reserved top bit taken as written
            ctrl_q <= i_wdata & `PDM_CTRL_WMASK;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            if (i_addr == `PDM_OFS_CTRL_STATUS) begin
                o_rdata <= ctrl_q;
            end else if (i_addr == `PDM_OFS_PD_STATUS) begin
                o_rdata <= {26'h0000000, emu_att, entry_busy, wake_q, state_q};
            end else begin
                o_rdata <= 32'h0000_0000;
            end
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // entry delay
    // ------------------------------------------------------------------------
    pdm_entry_delay u_delay (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(sel_wr && !deep),
        .i_cancel(state_q != ST_RUN),
        .o_done(entry_done),
        .o_busy(entry_busy)
    );

    // ------------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------------
    reg wake_isr;
    reg wake_now;

    always @* begin
        state_d = state_q;
        wake_now = 1'b0;
        wake_isr = 1'b0;
        case (state_q)
            ST_RUN: begin
                // a select write landing with done restarts the delay so the newest code wins
                if (entry_done && !emu_att && !sel_wr) begin
                    state_d = code_state(sel);
                end
            end
            ST_LIGHT: begin
                if (emu_att) begin
                    state_d = ST_RUN;
                    wake_now = 1'b1;
                end else if (irq_en) begin
                    state_d = ST_RUN;
                    wake_now = 1'b1;
                    wake_isr = global_interrupt_gate && i_nmi_gate;
                end else if (irq_any && wake_q == WAKE_ANY) begin
                    state_d = ST_RUN;
                    wake_now = 1'b1;
                end
            end
            default: begin
                state_d = state_q;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RUN;
            wake_q <= WAKE_NONE;
        end else begin
            state_q <= state_d;
            // wake method is latched at entry so it stays fixed while the core sleeps
            if (state_q == ST_RUN && state_d != ST_RUN) begin
                wake_q <= code_wake(sel);
            end else if (state_d == ST_RUN) begin
                wake_q <= WAKE_NONE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // next values of the registered outputs
    // ------------------------------------------------------------------------
    reg cpu_clk_en_d;
    reg xfer_clk_en_d;
    reg pll_out_en_d;
    reg refclk_en_d;
    reg io_freeze_d;
    reg run_isr_d;
    reg resume_d;
    reg emu_spin_idle_d;
    reg emu_pc_write_fail_d;

    always @* begin
        // clock tree follows the next state so the gates switch with it
        cpu_clk_en_d = (state_d == ST_RUN);
        xfer_clk_en_d = !is_deep(state_d);
        pll_out_en_d = !is_deep(state_d);
        refclk_en_d = (state_d != ST_PLL_STOP);
        io_freeze_d = is_deep(state_d);

        // wake pulses and emulation answers
        run_isr_d = wake_now && wake_isr;
        resume_d = wake_now;
        emu_spin_idle_d = deep && emu_cmd;
        emu_pc_write_fail_d = deep && emu_pcw;
    end

    // ------------------------------------------------------------------------
    // clock, pll, freeze and emulation outputs
    // ------------------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_clk_en <= 1'b1;
            o_xfer_clk_en <= 1'b1;
            o_pll_out_en <= 1'b1;
            o_refclk_en <= 1'b1;
            o_io_freeze <= 1'b0;
            o_run_isr <= 1'b0;
            o_resume <= 1'b0;
            o_emu_spin_idle <= 1'b0;
            o_emu_pc_write_fail <= 1'b0;
        end else begin
            o_cpu_clk_en <= cpu_clk_en_d;
            o_xfer_clk_en <= xfer_clk_en_d;
            o_pll_out_en <= pll_out_en_d;
            o_refclk_en <= refclk_en_d;
            o_io_freeze <= io_freeze_d;
            o_run_isr <= run_isr_d;
            o_resume <= resume_d;
            o_emu_spin_idle <= emu_spin_idle_d;
            o_emu_pc_write_fail <= emu_pc_write_fail_d;
        end
    end

endmodule // pdm_power_down

// ### verification/pdm_core_model.sv
/* core interrupt logic model: holds a pending interrupt until the wake.
   assumes one-cycle raise pulses from the bench and the design's resume pulse. */
`timescale 1ns/1ps
module pdm_core_model (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_raise_any,
    input wire i_raise_en,
    input wire i_resume,
    output reg o_irq_any,
    output reg o_irq_enabled
);
    // an enabled interrupt is also counted as any interrupt
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_any <= 1'b0;
            o_irq_enabled <= 1'b0;
        end else if (i_resume) begin
            o_irq_any <= 1'b0;
            o_irq_enabled <= 1'b0;
        end else begin
            o_irq_any <= o_irq_any | i_raise_any | i_raise_en;
            o_irq_enabled <= o_irq_enabled | i_raise_en;
        end
    end
endmodule // pdm_core_model

// ### verification/pdm_power_down_assertions.sv
/* port checker for the power-down controller.
   assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_checker (
    input wire i_clk, input wire i_rst_n, input wire [`PDM_ADDR_W-1:0] i_addr, input wire [31:0] i_wdata,
    input wire i_wr, input wire i_rd, input wire i_emu_attached, input wire [31:0] o_rdata,
    input wire o_cpu_clk_en, input wire o_xfer_clk_en, input wire o_pll_out_en, input wire o_refclk_en,
    input wire o_io_freeze, input wire o_run_isr, input wire o_resume, input wire o_emu_pc_write_fail
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire sel_wr = i_wr && i_addr == `PDM_OFS_CTRL_STATUS && o_cpu_clk_en && !o_io_freeze && !i_emu_attached;
    wire [5:0] code = i_wdata[15:10];
    wire rsvd = code != `PDM_CODE_NONE && code != `PDM_CODE_LIGHT_EN && code != `PDM_CODE_LIGHT_ANY
        && code != `PDM_CODE_HALT && code != `PDM_CODE_PLL_STOP;
    sequence s_entry_wait;
        o_cpu_clk_en [*8] ##1 o_cpu_clk_en [*2];
    endsequence
    chk_light_entry_delay: assert property (sel_wr && code == `PDM_CODE_LIGHT_EN |=> s_entry_wait ##1
        (!o_cpu_clk_en && o_xfer_clk_en && o_pll_out_en)) else $error("light sleep entry timing wrong");
    chk_halt_outputs: assert property (sel_wr && code == `PDM_CODE_HALT |-> ##11
        (!o_pll_out_en && o_refclk_en && o_io_freeze)) else $error("clock halt outputs wrong");
    chk_pll_stop_outputs: assert property (sel_wr && code == `PDM_CODE_PLL_STOP |-> ##11
        (!o_refclk_en && !o_pll_out_en && o_io_freeze)) else $error("pll stop outputs wrong");
    chk_reserved_no_sleep: assert property (sel_wr && rsvd |-> ##11 (o_cpu_clk_en && o_pll_out_en))
        else $error("reserved code entered sleep");
    chk_deep_sticky: assert property (o_io_freeze |=> o_io_freeze)
        else $error("deep sleep left without reset");
    chk_isr_with_resume: assert property (o_run_isr |-> o_resume)
        else $error("service routine without resume");
    chk_resume_wakes: assert property (o_resume |-> $rose(o_cpu_clk_en) ##1 !o_resume)
        else $error("resume not tied to clock restart");
    chk_light_xfer_runs: assert property (!o_cpu_clk_en && !o_io_freeze |-> o_xfer_clk_en && o_pll_out_en)
        else $error("transfer clock stopped in light sleep");
    chk_pc_fail_deep: assert property (o_emu_pc_write_fail |-> o_io_freeze)
        else $error("pc write failed outside deep sleep");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside read answer");
endmodule // pdm_checker
bind pdm_power_down pdm_checker pdm_checker_i (.*);

// ### verification/pdm_power_down_tb.sv
/* self-checking bench for the power-down controller.
   assumes the core model and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_power_down_tb;
    reg i_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [31:0] i_wdata = 32'h0000_0000;
    reg i_wr = 1'b0, i_rd = 1'b0, i_nmi_gate = 1'b1, i_emu_attached = 1'b0, i_emu_exec_cmd = 1'b0;
    reg i_emu_pc_write = 1'b0, raise_any = 1'b0, raise_en = 1'b0;
    wire irq_any, irq_en, cpu_en, xfer_en, pll_en, ref_en, freeze, run_isr, resume, spin, pcfail;
    wire [31:0] o_rdata;
    integer err_count = 0, n_compared = 0, cyc = 0, i;
    initial forever #2 i_clk = ~i_clk;
    pdm_power_down pdm_power_down_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_nmi_gate(i_nmi_gate), .i_irq_any(irq_any),
        .i_irq_enabled(irq_en), .i_emu_attached(i_emu_attached), .i_emu_exec_cmd(i_emu_exec_cmd),
        .i_emu_pc_write(i_emu_pc_write), .o_cpu_clk_en(cpu_en), .o_xfer_clk_en(xfer_en), .o_pll_out_en(pll_en),
        .o_refclk_en(ref_en), .o_io_freeze(freeze), .o_run_isr(run_isr), .o_resume(resume),
        .o_emu_spin_idle(spin), .o_emu_pc_write_fail(pcfail));
    pdm_core_model pdm_core_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_raise_any(raise_any),
        .i_raise_en(raise_en), .i_resume(resume), .o_irq_any(irq_any), .o_irq_enabled(irq_en));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge i_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
            @(posedge i_clk); i_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] exp);
        begin
            @(posedge i_clk); i_addr <= a; i_rd <= 1'b1;
            @(posedge i_clk); i_rd <= 1'b0;
            @(negedge i_clk); check(o_rdata, exp);
        end
    endtask
    // select write, then sample just after the edge where the mode applies
    task sleep(input [31:0] w);
        begin
            wr(4'h0, w);
            repeat (10) @(posedge i_clk);
            @(negedge i_clk);
        end
    endtask
    task irq(input en);
        begin
            @(posedge i_clk); raise_any <= ~en; raise_en <= en;
            @(posedge i_clk); raise_any <= 1'b0; raise_en <= 1'b0;
        end
    endtask
    task wait_resume;
        integer k;
        begin
            k = 0;
            while (resume !== 1'b1 && k < 20) begin
                @(negedge i_clk); k = k + 1;
            end
            check(resume, 1);
        end
    endtask
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(4'h0, 32'h0000_0000);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0000_0000);
        wr(4'h0, 32'hffff_7fff);
        rd(4'h0, 32'h0000_7c01);
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        check(cpu_en, 1);
        sleep(32'h0000_2401);
        check({cpu_en, xfer_en, pll_en, ref_en}, 4'h7);
        rd(4'h1, 32'h0000_0005);
        irq(1'b0);
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        check(cpu_en, 0);
        irq(1'b1);
        wait_resume;
        check(run_isr, 1);
        rd(4'h0, 32'h0000_0001);
        sleep(32'h0000_4400);
        irq(1'b0);
        wait_resume;
        check(run_isr, 0);
        @(posedge i_clk);
        i_nmi_gate <= 1'b0;
        sleep(32'h0000_4401);
        irq(1'b1);
        wait_resume;
        check(run_isr, 0);
        @(posedge i_clk);
        i_emu_attached <= 1'b1;
        sleep(32'h0000_2401);
        check(cpu_en, 1);
        wr(4'h0, 32'h0000_0000);
        i_emu_attached <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (i = 0; i < 2; i = i + 1) begin
            sleep(i ? 32'h0000_7000 : 32'h0000_6800);
            check({pll_en, ref_en, freeze, xfer_en}, i ? 4'h2 : 4'h6);
            irq(1'b1);
            i_emu_exec_cmd <= 1'b1;
            i_emu_pc_write <= 1'b1;
            repeat (6) @(posedge i_clk);
            @(negedge i_clk);
            check({freeze, spin, pcfail}, 3'h7);
            wr(4'h0, 32'h0000_0000);
            rd(4'h0, i ? 32'h0000_7000 : 32'h0000_6800);
            rd(4'h1, i ? 32'h0000_0003 : 32'h0000_0002);
            @(posedge i_clk);
            i_emu_exec_cmd <= 1'b0;
            i_emu_pc_write <= 1'b0;
            i_rst_n <= 1'b0;
            repeat (2) @(posedge i_clk);
            i_rst_n <= 1'b1;
            @(negedge i_clk);
            check({cpu_en, pll_en, ref_en, freeze}, 4'he);
        end
        finish_test;
    end
endmodule // pdm_power_down_tb
